// ---- src/pmicsm_top.sv ----
// Summary of operation
// - standby to run on deasserted effective standby
// - run to standby on asserted effective standby
// - hard watchdog event enters watchdog reset
// - after 30 us return to system on
// - watchdog count at limit forces fault power-down
// - low-power select set leaves low-power off automatically
// - level mode needs request high and good supervision
// - edge mode starts on falling power request
// - test bench mode leaves low-power off
// - self-test exits on pass or test bench
// - no self-test variant goes straight to quiescent
// - self-test checks oscillator, mirror crc, monitors
// - fail-safe lock after repeated fault cycles
// - safe output held while non-safe, externally forceable
// - safety writes need challenge and response
// - no self-test variant reads safety bits zero
// - processor reset released in the same cycle as system on
// - fault count at limit forces power-down
`timescale 1ns/1ps
`include "pmicsm_map.svh"

module pmicsm_top #(
    parameter bit SELF_TEST_FITTED = 1'b1,
    parameter int OSC_WINDOW       = 200,
    parameter int OSC_EXPECT       = 100
) (
    input  wire logic                  clk_sys,
    input  wire logic                  resetn,
    input  wire pmicsm_pkg::pmicsm_bus_t   bus,
    output logic [15:0]                rdata,
    input  wire logic                  standby_pin,
    input  wire logic                  power_on_request,
    input  wire logic                  test_bench_mode_enable,
    input  wire pmicsm_pkg::pmicsm_sup_t   sup,
    input  wire pmicsm_pkg::pmicsm_stest_t stest,
    input  wire logic                  hs_osc_tick,
    input  wire logic                  hard_wd_event,
    input  wire logic                  regulator_fault_event,
    input  wire logic                  pwrup_seq_done,
    input  wire logic                  pwrdn_seq_done,
    input  wire logic                  safe_state_in_n,
    output logic                       processor_reset_out_n,
    output logic                       pwrup_seq_start,
    output logic                       pwrdn_seq_start,
    output logic                       system_run,
    output logic                       system_standby,
    output logic                       safe_state_out,
    output logic                       safe_state_oe,
    output logic [3:0]                 state_code
);
    import pmicsm_pkg::*;

    localparam int WD_CYC = (`PMICSM_WD_RESET_NS + `PMICSM_CLK_PERIOD_NS - 1)
                            / `PMICSM_CLK_PERIOD_NS;
    localparam int OSC_LO = OSC_EXPECT * (100 - `PMICSM_OSC_TOL_PCT) / 100;
    localparam int OSC_HI = OSC_EXPECT * (100 + `PMICSM_OSC_TOL_PCT) / 100;

    // refuse sizes the 10-bit counters cannot hold
    if (OSC_WINDOW < 1 || OSC_WINDOW > 1023 || OSC_HI > 1023 || WD_CYC > 1023)
    begin : g_bad_size
        $error("pmicsm_top: counter parameter out of range");
    end

    pmicsm_state_t state_r;
    pmicsm_state_t state_nxt;
    logic [6:0]    ctrl_r;
    logic [11:0]   safety_r;
    logic [7:0]    chal_r;
    logic [7:0]    resp_r;
    logic [3:0]    wd_cnt_r;
    logic [3:0]    regulator_fault_count_r;
    logic [3:0]    failsafe_cycle_count_r;
    logic [9:0]    wd_tmr_r;
    logic [9:0]    win_r;
    logic [9:0]    ticks_r;
    logic          power_on_request_prev_r;
    logic          fault_pd_r;
    logic          stest_fail_r;
    logic          safe_forced_r;
    logic          reset_n_r;
    logic [15:0]   rdata_r;
    logic          safe_oe_r;

    logic stby_eff;
    logic power_on_request_fall;
    logic sup_ok;
    logic power_on_request_evt;
    logic lp_go;
    logic qpu_go;
    logic sys_on;
    logic st_eval;
    logic st_pass;
    logic wr_ctrl;
    logic wr_safety;
    logic sec_ok;
    logic nonsafe;

    wire [3:0] wd_lim    = safety_r[3:0];
    wire [3:0] fault_lim = safety_r[7:4];
    wire [3:0] fs_lim    = safety_r[11:8];

    // pin and mode decode
    assign stby_eff   = standby_pin ^ ctrl_r[`PMICSM_C_STBY_INV];
    assign power_on_request_fall = power_on_request_prev_r & ~power_on_request;
    assign sup_ok     = sup.vin_in_window & sup.die_temp_ok
                        & ~sup.trim_load_fail & ~sup.fuse_load_fail;
    assign power_on_request_evt  = ctrl_r[`PMICSM_C_EDGE_MODE] ? power_on_request_fall
                                                    : power_on_request;
    assign sys_on     = state_r == pmicsm_run_state
                        || state_r == pmicsm_standby_state;

    // exit from low-power off
    always_comb
    begin
        if (test_bench_mode_enable)
            lp_go = 1'b1;
        else if (ctrl_r[`PMICSM_C_LPM_SEL])
            lp_go = 1'b1;
        else
            lp_go = power_on_request_evt & sup_ok;
    end

    // quiescent state waits for a power-on event when not transitory
    assign qpu_go = (~ctrl_r[`PMICSM_C_LPM_SEL] & ~test_bench_mode_enable)
                    | (power_on_request_evt & sup_ok);

    // self-test verdict: oscillator window, mirror crc, monitor tests
    assign st_eval = win_r == 10'(OSC_WINDOW)
                     && stest.analog_builtin_test_done;
    assign st_pass = ticks_r >= 10'(OSC_LO) && ticks_r <= 10'(OSC_HI)
                     && stest.mirror_crc_ok
                     && stest.analog_builtin_test_ok;

    // next power state
    always_comb
    begin
        state_nxt = state_r;
        case (state_r)
            pmicsm_low_power_off_state:
                if (lp_go)
                    state_nxt = SELF_TEST_FITTED ? pmicsm_self_test_state
                              : pmicsm_quiescent_power_up_state;
            pmicsm_self_test_state:
                if (test_bench_mode_enable || (st_eval && st_pass))
                    state_nxt = pmicsm_quiescent_power_up_state;
                else if (st_eval)
                    state_nxt = pmicsm_low_power_off_state;
            pmicsm_quiescent_power_up_state:
                if (qpu_go)
                    state_nxt = pmicsm_power_up_state;
            pmicsm_power_up_state:
                if (pwrup_seq_done)
                    state_nxt = stby_eff ? pmicsm_standby_state
                                         : pmicsm_run_state;
            pmicsm_run_state,
            pmicsm_standby_state:
                if (hard_wd_event)
                    state_nxt = pmicsm_wd_reset_state;
                else if (regulator_fault_count_r == fault_lim || !sup.die_temp_ok)
                    state_nxt = pmicsm_power_down_state;
                else if (stby_eff)
                    state_nxt = pmicsm_standby_state;
                else
                    state_nxt = pmicsm_run_state;
            pmicsm_wd_reset_state:
                if (wd_cnt_r == wd_lim)
                    state_nxt = pmicsm_power_down_state;
                else if (wd_tmr_r == 10'(WD_CYC - 1))
                    state_nxt = stby_eff ? pmicsm_standby_state
                                         : pmicsm_run_state;
            pmicsm_power_down_state:
                if (pwrdn_seq_done)
                    state_nxt = (SELF_TEST_FITTED && fault_pd_r
                                 && failsafe_cycle_count_r == fs_lim)
                              ? pmicsm_fail_safe_state
                              : pmicsm_low_power_off_state;
            pmicsm_fail_safe_state:
                state_nxt = pmicsm_fail_safe_state;
            default:
                state_nxt = pmicsm_low_power_off_state;
        endcase
    end

    // state register and registered state outputs
    always_ff @(posedge clk_sys)
    begin
        if (!resetn)
        begin
            state_r         <= pmicsm_low_power_off_state;
            power_on_request_prev_r    <= 1'b0;
            system_run      <= 1'b0;
            system_standby  <= 1'b0;
            pwrup_seq_start <= 1'b0;
            pwrdn_seq_start <= 1'b0;
            state_code      <= 4'h0;
        end
        else
        begin
            state_r         <= state_nxt;
            power_on_request_prev_r    <= power_on_request;
            system_run      <= state_nxt == pmicsm_run_state;
            system_standby  <= state_nxt == pmicsm_standby_state;
            pwrup_seq_start <= state_nxt == pmicsm_power_up_state;
            pwrdn_seq_start <= state_nxt == pmicsm_power_down_state;
            state_code      <= state_nxt;
        end
    end

    // processor reset follows the power state
    always_ff @(posedge clk_sys)
    begin
        if (!resetn)
            reset_n_r <= 1'b0;
        else if (state_r == pmicsm_power_up_state && pwrup_seq_done)
            reset_n_r <= 1'b1;
        else if (state_nxt == pmicsm_wd_reset_state && sys_on)
            reset_n_r <= 1'b0;
        else if (state_r == pmicsm_wd_reset_state && state_nxt != state_r
                 && state_nxt != pmicsm_power_down_state)
            reset_n_r <= 1'b1;
        else if (!sys_on && state_r != pmicsm_wd_reset_state)
            reset_n_r <= 1'b0;
    end

    // watchdog reset timer
    always_ff @(posedge clk_sys)
    begin
        if (!resetn || state_r != pmicsm_wd_reset_state)
            wd_tmr_r <= 10'h000;
        else if (wd_tmr_r != 10'(WD_CYC - 1))
            wd_tmr_r <= wd_tmr_r + 10'h001;
    end

    // watchdog, regulator fault and fail-safe counters
    always_ff @(posedge clk_sys)
    begin
        if (!resetn)
        begin
            wd_cnt_r    <= 4'h0;
            regulator_fault_count_r <= 4'h0;
            failsafe_cycle_count_r    <= 4'h0;
            fault_pd_r  <= 1'b0;
        end
        else
        begin
            if (state_r == pmicsm_low_power_off_state)
            begin
                wd_cnt_r    <= 4'h0;
                regulator_fault_count_r <= 4'h0;
            end
            else if (sys_on)
            begin
                if (hard_wd_event && wd_cnt_r != 4'hf)
                    wd_cnt_r <= wd_cnt_r + 4'h1;
                if (regulator_fault_event && regulator_fault_count_r != 4'hf)
                    regulator_fault_count_r <= regulator_fault_count_r + 4'h1;
            end
            if (state_nxt == pmicsm_power_down_state
                && state_r != pmicsm_power_down_state)
                fault_pd_r <= 1'b1;
            else if (state_r == pmicsm_low_power_off_state)
                fault_pd_r <= 1'b0;
            // a fault cycle counts before any software clear
            if (SELF_TEST_FITTED && state_nxt == pmicsm_power_down_state
                && state_r != pmicsm_power_down_state && failsafe_cycle_count_r != 4'hf)
                failsafe_cycle_count_r <= failsafe_cycle_count_r + 4'h1;
            else if (wr_ctrl && bus.wdata[`PMICSM_C_FS_CLR])
                failsafe_cycle_count_r <= 4'h0;
        end
    end

    // oscillator tick count over a fixed window during self-test
    always_ff @(posedge clk_sys)
    begin
        if (!resetn || state_r != pmicsm_self_test_state)
        begin
            win_r   <= 10'h000;
            ticks_r <= 10'h000;
        end
        else if (win_r != 10'(OSC_WINDOW))
        begin
            win_r <= win_r + 10'h001;
            if (hs_osc_tick && ticks_r != 10'h3ff)
                ticks_r <= ticks_r + 10'h001;
        end
    end

    // self-test fail flag, set wins over software clear
    always_ff @(posedge clk_sys)
    begin
        if (!resetn)
            stest_fail_r <= 1'b0;
        else if (SELF_TEST_FITTED && state_r == pmicsm_self_test_state
                 && st_eval && !st_pass && !test_bench_mode_enable)
            stest_fail_r <= 1'b1;
        else if (bus.wr && bus.addr == `PMICSM_A_STATUS
                 && bus.wdata[`PMICSM_S_STEST_FAIL])
            stest_fail_r <= 1'b0;
    end

    // register writes
    assign wr_ctrl   = bus.wr && bus.addr == `PMICSM_A_CTRL;
    assign wr_safety = bus.wr && bus.addr == `PMICSM_A_SAFETY;
    assign sec_ok    = !ctrl_r[`PMICSM_C_SEC_EN] || resp_r == ~chal_r;

    // control register, variant bits held at zero
    always_ff @(posedge clk_sys)
    begin
        if (!resetn)
            ctrl_r <= `PMICSM_CTRL_RST;
        else if (wr_ctrl)
        begin
            ctrl_r[2:0] <= bus.wdata[2:0];
            ctrl_r[`PMICSM_C_ASS_EN] <= SELF_TEST_FITTED
                                        & bus.wdata[`PMICSM_C_ASS_EN];
            ctrl_r[`PMICSM_C_SEC_EN] <= SELF_TEST_FITTED
                                        & bus.wdata[`PMICSM_C_SEC_EN];
            ctrl_r[6:5] <= 2'b00; // action bits only
        end
    end

    // safety limits behind the secure write check
    always_ff @(posedge clk_sys)
    begin
        if (!resetn)
            safety_r <= `PMICSM_SAFETY_RST;
        else if (wr_safety && sec_ok)
            safety_r <= bus.wdata[11:0];
    end

    // challenge lfsr advances after each guarded attempt
    always_ff @(posedge clk_sys)
    begin
        if (!resetn)
        begin
            chal_r <= `PMICSM_CHAL_SEED;
            resp_r <= 8'h00;
        end
        else if (wr_safety && ctrl_r[`PMICSM_C_SEC_EN])
        begin
            chal_r <= {chal_r[6:0],
                       chal_r[7] ^ chal_r[5] ^ chal_r[4] ^ chal_r[3]};
            resp_r <= 8'h00;
        end
        else if (SELF_TEST_FITTED && bus.wr && bus.addr == `PMICSM_A_RESP)
            resp_r <= bus.wdata[7:0];
    end

    // safe state: non-safe while off or, when armed, any bad condition
    assign nonsafe = !sys_on || safe_forced_r
                     || (ctrl_r[`PMICSM_C_ASS_EN]
                         && (!sup_ok || regulator_fault_count_r != 4'h0));
    always_ff @(posedge clk_sys)
    begin
        if (!resetn)
        begin
            safe_forced_r  <= 1'b0;
            safe_oe_r      <= 1'b1;
            safe_state_out <= 1'b0;
        end
        else
        begin
            if (ctrl_r[`PMICSM_C_ASS_EN] && sys_on && !safe_oe_r
                && !safe_state_in_n)
                safe_forced_r <= 1'b1;
            else if (wr_ctrl && bus.wdata[`PMICSM_C_SAFE_CLR])
                safe_forced_r <= 1'b0;
            safe_oe_r      <= nonsafe;
            safe_state_out <= 1'b0;
        end
    end

    // read data one cycle after the strobe, unmapped reads zero
    always_ff @(posedge clk_sys)
    begin
        if (!resetn || !bus.rd)
            rdata_r <= 16'h0000;
        else
            case (bus.addr)
                `PMICSM_A_CTRL:   rdata_r <= {11'h000, ctrl_r[4:0]};
                `PMICSM_A_SAFETY: rdata_r <= {4'h0, safety_r};
                `PMICSM_A_STATUS: rdata_r <= {8'h00, safe_oe_r,
                                              safe_forced_r, stest_fail_r,
                                              reset_n_r, state_r};
                `PMICSM_A_COUNTS: rdata_r <= {4'h0, failsafe_cycle_count_r,
                                              regulator_fault_count_r, wd_cnt_r};
                `PMICSM_A_CHAL:   rdata_r <= SELF_TEST_FITTED
                                             ? {8'h00, chal_r} : 16'h0000;
                `PMICSM_A_RESP:   rdata_r <= {8'h00, resp_r};
                default:          rdata_r <= 16'h0000;
            endcase
    end

    assign rdata                 = rdata_r;
    assign processor_reset_out_n = reset_n_r;
    assign safe_state_oe         = safe_oe_r;

    default clocking @(posedge clk_sys); endclocking
    default disable iff (!resetn);

    // transition checks
    chk_stby_to_run: assert property (
        state_r == pmicsm_standby_state && !stby_eff && !hard_wd_event
        && regulator_fault_count_r != fault_lim && sup.die_temp_ok
        |=> state_r == pmicsm_run_state)
        else $error("standby did not go to run");
    chk_run_to_stby: assert property (
        state_r == pmicsm_run_state && stby_eff && !hard_wd_event
        && regulator_fault_count_r != fault_lim && sup.die_temp_ok
        |=> state_r == pmicsm_standby_state && system_standby)
        else $error("run did not go to standby");
    chk_wd_entry: assert property (
        sys_on && hard_wd_event
        |=> state_r == pmicsm_wd_reset_state && !processor_reset_out_n)
        else $error("watchdog event not handled");
    chk_wd_return: assert property (
        $rose(state_r == pmicsm_wd_reset_state) && wd_cnt_r < wd_lim
        |-> (state_r == pmicsm_wd_reset_state)[*8] ##[1:760] sys_on)
        else $error("watchdog reset timing wrong");
    chk_wd_min_time: assert property (
        $fell(state_r == pmicsm_wd_reset_state) && sys_on
        |-> $past(wd_tmr_r) == 10'(WD_CYC - 1))
        else $error("watchdog reset left early");
    chk_wd_limit: assert property (
        state_r == pmicsm_wd_reset_state && wd_cnt_r == wd_lim
        |=> state_r == pmicsm_power_down_state ##1 pwrdn_seq_start)
        else $error("watchdog limit ignored");
    chk_auto_start: assert property (
        state_r == pmicsm_low_power_off_state
        && ctrl_r[`PMICSM_C_LPM_SEL] && !test_bench_mode_enable
        |=> state_r != pmicsm_low_power_off_state)
        else $error("automatic start missing");
    chk_level_hold: assert property (
        state_r == pmicsm_low_power_off_state && !test_bench_mode_enable
        && !ctrl_r[`PMICSM_C_LPM_SEL] && !ctrl_r[`PMICSM_C_EDGE_MODE]
        && !(power_on_request && sup_ok)
        |=> state_r == pmicsm_low_power_off_state)
        else $error("left off without request");
    chk_edge_start: assert property (
        state_r == pmicsm_low_power_off_state && !test_bench_mode_enable
        && ctrl_r[`PMICSM_C_EDGE_MODE] && power_on_request_fall && sup_ok
        |=> state_r != pmicsm_low_power_off_state)
        else $error("falling request ignored");
    chk_fault_limit: assert property (
        sys_on && !hard_wd_event && regulator_fault_count_r == fault_lim
        |=> state_r == pmicsm_power_down_state)
        else $error("fault limit ignored");
    chk_reset_release: assert property (
        $rose(sys_on) |-> processor_reset_out_n)
        else $error("system on with reset held");
    chk_secure_reject: assert property (
        wr_safety && ctrl_r[`PMICSM_C_SEC_EN] && resp_r != ~chal_r
        |=> $stable(safety_r))
        else $error("unchecked safety write");

endmodule

// ---- src/pmicsm_map.svh ----
`ifndef PMICSM_MAP_SVH
`define PMICSM_MAP_SVH

// register indexes on the plain register port
`define PMICSM_A_CTRL       4'h0
`define PMICSM_A_SAFETY     4'h1
`define PMICSM_A_STATUS     4'h2
`define PMICSM_A_COUNTS     4'h3
`define PMICSM_A_CHAL       4'h4
`define PMICSM_A_RESP       4'h5

// control register fields
`define PMICSM_C_STBY_INV   0
`define PMICSM_C_LPM_SEL    1
`define PMICSM_C_EDGE_MODE  2
`define PMICSM_C_ASS_EN     3
`define PMICSM_C_SEC_EN     4
`define PMICSM_C_SAFE_CLR   5
`define PMICSM_C_FS_CLR     6

// status register fields
`define PMICSM_S_RESET_N    4
`define PMICSM_S_STEST_FAIL 5
`define PMICSM_S_SAFE_ACT   6
`define PMICSM_S_SAFE_OUT   7

// reset values
`define PMICSM_CTRL_RST     7'h00
`define PMICSM_SAFETY_RST   12'h433
`define PMICSM_CHAL_SEED    8'h5a

// timing
`define PMICSM_CLK_PERIOD_NS 40
`define PMICSM_WD_RESET_NS   30000
`define PMICSM_OSC_TOL_PCT   15

`endif

// ---- src/pmicsm_pkg.sv ----
package pmicsm_pkg;

    // top-level power states
    typedef enum logic [3:0] {
        pmicsm_low_power_off_state,
        pmicsm_self_test_state,
        pmicsm_quiescent_power_up_state,
        pmicsm_power_up_state,
        pmicsm_run_state,
        pmicsm_standby_state,
        pmicsm_wd_reset_state,
        pmicsm_power_down_state,
        pmicsm_fail_safe_state
    } pmicsm_state_t;

    // supply and load supervision levels
    typedef struct packed {
        logic vin_in_window;
        logic die_temp_ok;
        logic trim_load_fail;
        logic fuse_load_fail;
    } pmicsm_sup_t;

    // self-test results from the analog side
    typedef struct packed {
        logic mirror_crc_ok;
        logic analog_builtin_test_ok;
        logic analog_builtin_test_done;
    } pmicsm_stest_t;

    // register port request
    typedef struct packed {
        logic [3:0]  addr;
        logic [15:0] wdata;
        logic        wr;
        logic        rd;
    } pmicsm_bus_t;

endpackage

// ---- tb/pmicsm_host_model.sv ----
`timescale 1ns/1ps
module pmicsm_host_model #(
    parameter int TICK_DIV = 2
) (
    input  wire logic       clk_sys,
    input  wire logic       resetn,
    input  wire logic [7:0] seq_delay,
    input  wire logic       pwrup_seq_start,
    input  wire logic       pwrdn_seq_start,
    input  wire logic       safe_state_oe,
    output logic            pwrup_seq_done,
    output logic            pwrdn_seq_done,
    output logic            hs_osc_tick,
    output logic            safe_state_in_n
);
    int cnt_r;
    int div_r;
    // sequencer stand-in, answers after a chosen delay
    always_ff @(posedge clk_sys)
    begin
        if (!resetn || !(pwrup_seq_start || pwrdn_seq_start))
            cnt_r <= 0;
        else
            cnt_r <= cnt_r + 1;
        div_r <= (!resetn || div_r == TICK_DIV - 1) ? 0 : div_r + 1;
    end
    assign pwrup_seq_done = pwrup_seq_start && cnt_r >= int'(seq_delay);
    assign pwrdn_seq_done = pwrdn_seq_start && cnt_r >= int'(seq_delay);
    // oscillator ticks at the nominal rate
    assign hs_osc_tick = (div_r == 0);
    // open-drain safe pin with pull-up
    assign safe_state_in_n = !safe_state_oe;
endmodule

// ---- tb/tb.sv ----
`timescale 1ns/1ps
module tb;
    import pmicsm_pkg::*;
    logic          clk_sys, resetn, standby_pin, power_on_request, p;
    logic          test_bench_mode_enable, hard_wd_event, regulator_fault_event;
    logic          pwrup_seq_done, pwrdn_seq_done, pwrup_seq_start;
    logic          pwrdn_seq_start, hs_osc_tick, safe_state_in_n;
    logic          processor_reset_out_n, safe_state_oe;
    logic          system_run, system_standby, safe_state_out;
    logic [7:0]    seq_delay;
    logic [3:0]    state_code;
    logic [15:0]   rdata, d;
    pmicsm_bus_t   bus;
    pmicsm_sup_t   sup;
    pmicsm_stest_t stest;
    int            mismatches, checks, cyc, t0;

    pmicsm_top DUT (.clk_sys, .resetn, .bus, .rdata, .standby_pin,
        .power_on_request, .test_bench_mode_enable, .sup, .stest,
        .hs_osc_tick, .hard_wd_event, .regulator_fault_event,
        .pwrup_seq_done, .pwrdn_seq_done, .safe_state_in_n,
        .processor_reset_out_n, .pwrup_seq_start, .pwrdn_seq_start,
        .system_run, .system_standby, .safe_state_out,
        .safe_state_oe, .state_code);
    pmicsm_host_model host (.clk_sys, .resetn, .seq_delay, .pwrup_seq_start,
        .pwrdn_seq_start, .safe_state_oe, .pwrup_seq_done, .pwrdn_seq_done,
        .hs_osc_tick, .safe_state_in_n);

    // clock and hang guard
    initial
    begin
        clk_sys = 1'b0;
        forever #20 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys)
    begin
        cyc++;
        if (cyc == 12000)
        begin
            mismatches++;
            test_done();
        end
    end

    task automatic chk(string n, logic [15:0] got, logic [15:0] exp);
        checks++;
        if (got !== exp)
        begin
            mismatches++;
            $display("Error %s expected %h seen %h", n, exp, got);
        end
    endtask
    task automatic wr(logic [3:0] a, logic [15:0] v);
        bus.addr <= a;
        bus.wdata <= v;
        bus.wr <= 1'b1;
        @(posedge clk_sys);
        bus.wr <= 1'b0;
        #1;
    endtask
    task automatic rd(logic [3:0] a);
        bus.addr <= a;
        bus.rd <= 1'b1;
        @(posedge clk_sys);
        bus.rd <= 1'b0;
        #1 d = rdata;
    endtask
    // bounded wait for a state, then compare
    task automatic wait_st(logic [3:0] s, int lim);
        int n;
        n = 0;
        #1;
        while (state_code !== s && n < lim)
        begin
            @(posedge clk_sys);
            #1 n++;
        end
        chk("state", {12'h000, state_code}, {12'h000, s});
    endtask
    task automatic do_reset();
        resetn <= 1'b0;
        repeat (4) @(posedge clk_sys);
        resetn <= 1'b1;
        @(posedge clk_sys);
        #1;
    endtask
    task automatic test_done();
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // main sequence
    initial
    begin
        void'($urandom(32'h357f));
        {resetn, standby_pin, power_on_request, p} = 4'h0;
        {test_bench_mode_enable, hard_wd_event, regulator_fault_event} = 3'h0;
        bus = '0;
        sup = 4'hc;
        stest = 3'h7;
        seq_delay = 8'(4 + $urandom % 16);
        do_reset();
        chk("rst", {processor_reset_out_n, safe_state_oe, state_code}, 16'h0010);
        chk("safeout", {15'h0, safe_state_out}, 16'h0000);
        wr(4'h0, 16'h0002);
        rd(4'h0);
        chk("ctrl", d, 16'h0002);
        rd(4'hf);
        chk("unmapped", d, 16'h0000);
        wait_st(4'h1, 4);
        wait_st(4'h2, 400);
        power_on_request <= 1'b1;
        wait_st(4'h4, 60);
        chk("rstout", {15'h0, processor_reset_out_n}, 16'h0001);
        $display("power-up test done");
        for (int i = 0; i < 12; i++)
        begin
            if (i == 6)
                wr(4'h0, 16'h0003);
            p = 1'($urandom);
            standby_pin <= p;
            wait_st((p ^ (i >= 6)) ? 4'h5 : 4'h4, 4);
            d = (p ^ (i >= 6)) ? 16'h0001 : 16'h0002;
            chk("run", {14'h0, system_run, system_standby}, d);
        end
        standby_pin <= 1'b1;
        wait_st(4'h4, 4);
        chk("safeoe", {15'h0, safe_state_oe}, 16'h0000);
        $display("standby test done");
        for (int i = 1; i <= 3; i++)
        begin
            hard_wd_event <= 1'b1;
            @(posedge clk_sys);
            hard_wd_event <= 1'b0;
            wait_st(4'h6, 4);
            rd(4'h3);
            chk("wdcnt", {12'h000, d[3:0]}, 16'(i));
            t0 = cyc;
            wait_st(i < 3 ? 4'h4 : 4'h7, 800);
            if (i < 3)
                chk("wdtime", 16'(cyc - t0 >= 745), 16'h0001);
        end
        $display("watchdog test done");
        power_on_request <= 1'b1;
        sup.vin_in_window <= 1'b0;
        do_reset();
        repeat (8) @(posedge clk_sys);
        wait_st(4'h0, 0);
        sup.vin_in_window <= 1'b1;
        wait_st(4'h1, 4);
        // failing mirror check sends the device back to off
        stest.mirror_crc_ok <= 1'b0;
        wait_st(4'h0, 210);
        rd(4'h2);
        chk("stfail", {15'h0, d[5]}, 16'h0001);
        stest.mirror_crc_ok <= 1'b1;
        // request low through reset so level mode cannot start early
        power_on_request <= 1'b0;
        do_reset();
        wr(4'h0, 16'h0004);
        power_on_request <= 1'b1;
        repeat (6) @(posedge clk_sys);
        wait_st(4'h0, 0);
        power_on_request <= 1'b0;
        wait_st(4'h1, 4);
        do_reset();
        test_bench_mode_enable <= 1'b1;
        wait_st(4'h1, 4);
        wait_st(4'h2, 10);
        $display("wake-up test done");
        // guarded limits: blind write refused, answered write lands
        wr(4'h0, 16'h0010);
        wr(4'h1, 16'h0555);
        rd(4'h1);
        chk("guarded", d, 16'h0433);
        rd(4'h4);
        wr(4'h5, {8'h00, ~d[7:0]});
        wr(4'h1, 16'h0222);
        rd(4'h1);
        chk("safety", d, 16'h0222);
        standby_pin <= 1'b0;
        power_on_request <= 1'b1;
        wait_st(4'h4, 60);
        // two regulator faults reach the new limit
        regulator_fault_event <= 1'b1;
        repeat (2) @(posedge clk_sys);
        regulator_fault_event <= 1'b0;
        wait_st(4'h7, 4);
        rd(4'h3);
        chk("counts", d, 16'h0120);
        $display("safety test done");
        test_done();
    end
endmodule
